// File: bench/host_serial_model.sv
// host end of the monitor serial line: sends frames, collects echoes
`timescale 1ns/1ps
module host_serial_model #(
  parameter int BIT_CYCLES = 8
) (
  input wire logic ref_clk,
  input wire logic dev_out,
  input wire logic dev_oe,
  output logic host_line,
  output logic [7:0] echo_byte,
  output logic echo_valid
);
  initial begin
    host_line = 1'b1;
    echo_byte = 8'h00;
    echo_valid = 1'b0;
  end

  // start, eight bits lsb first, stop; next byte only after the echo is over
  task automatic send(input logic [7:0] b);
    logic [9:0] fr;
    int n;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      host_line = fr[i];
      repeat (BIT_CYCLES) @(posedge ref_clk);
      #1;
    end
    n = 0;
    while (!dev_oe && n < 4 * BIT_CYCLES) begin
      @(posedge ref_clk);
      n++;
    end
    while (dev_oe && n < 16 * BIT_CYCLES) begin
      @(posedge ref_clk);
      n++;
    end
    #1;
  endtask : send

  // a missing stop bit gives no echo, which leaves a note in the bench queue
  always begin
    @(posedge ref_clk iff dev_oe);
    repeat (BIT_CYCLES / 2) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYCLES) @(posedge ref_clk);
      echo_byte[i] = dev_out;
    end
    repeat (BIT_CYCLES) @(posedge ref_clk);
    #1 echo_valid = dev_out;
    @(posedge ref_clk);
    #1 echo_valid = 1'b0;
    @(posedge ref_clk iff !dev_oe);
  end
endmodule : host_serial_model

// File: bench/monitor_entry_security_props.sv
// concurrent checks on echo framing, unlock, flash gating and commands
`timescale 1ns/1ps
module monitor_entry_security_props import monitor_entry_security_pkg::*; #(
  parameter int BIT_CYCLES = 1024,
  parameter int HOLD_CYCLES = ENTRY_HOLD_CYCLES
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic monitor_serial_pin_out,
  input wire logic monitor_serial_pin_oe,
  input wire mon_cmd_s cmd,
  input wire logic rsp_valid,
  input wire logic resume_pulse,
  input wire flash_req_s flash_req,
  input wire logic [7:0] flash_array_data,
  input wire logic [7:0] flash_rd_data,
  input wire logic flash_rd_valid,
  input wire logic illegal_addr_reset,
  input wire logic monitor_active,
  input wire logic security_unlocked
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  logic [3:0] starts, next_starts;
  logic [15:0] oe_len, next_oe_len;
  logic oe_q;
  logic done, locked;

  always_comb begin
    next_oe_len = monitor_serial_pin_oe ? oe_len + 16'h0001 : 16'h0000;
    next_starts = starts;
    if (monitor_serial_pin_oe && !oe_q && starts != 4'h8) begin
      next_starts = starts + 4'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      starts <= 4'h0;
      oe_len <= 16'h0000;
      oe_q <= 1'b0;
    end else begin
      starts <= next_starts;
      oe_len <= next_oe_len;
      oe_q <= monitor_serial_pin_oe;
    end
  end

  // one idle cycle of margin after the last echo before commands count
  assign done = starts == 4'h8 && !monitor_serial_pin_oe && !oe_q && monitor_active;
  assign locked = monitor_active && !security_unlocked;

  start_bit_low_a: assert property ($rose(monitor_serial_pin_oe) |-> !monitor_serial_pin_out)
    else $error("echo frame opened without a low start bit");
  echo_length_a: assert property ($fell(monitor_serial_pin_oe) |-> oe_len == FRAME_BITS * BIT_CYCLES)
    else $error("echo frame length wrong");
  unlock_count_a: assert property ($rose(security_unlocked) |-> starts == 4'h8)
    else $error("unlock before eight bytes");
  unlock_hold_a: assert property (security_unlocked |=> security_unlocked)
    else $error("unlock dropped without reset");
  locked_read_a: assert property (flash_req.valid && !flash_req.fetch && locked
    && flash_req.addr >= FLASH_LO_ADDR |=> flash_rd_valid && flash_rd_data == UNDEF_BYTE)
    else $error("locked flash read leaked data");
  open_read_a: assert property (flash_req.valid && !flash_req.fetch && security_unlocked |=> flash_rd_valid && flash_rd_data == $past(flash_array_data))
    else $error("unlocked flash read wrong");
  locked_fetch_a: assert property (flash_req.valid && flash_req.fetch && locked && flash_req.addr >= FLASH_LO_ADDR |=> illegal_addr_reset)
    else $error("locked fetch without illegal reset");
  open_fetch_a: assert property (flash_req.valid && flash_req.fetch && security_unlocked |=> !illegal_addr_reset)
    else $error("unlocked fetch trapped");
  user_fetch_a: assert property (flash_req.valid && flash_req.fetch && !monitor_active |=> !illegal_addr_reset)
    else $error("user mode fetch trapped");
  stack_answer_a: assert property (cmd.valid && cmd.op == read_stack_pointer_command && done |=> rsp_valid)
    else $error("stack pointer read unanswered");
  resume_go_a: assert property (cmd.valid && cmd.op == cmd_resume && done |=> resume_pulse)
    else $error("resume not performed");

  cover property ($rose(security_unlocked));
  cover property (illegal_addr_reset);
  cover property (resume_pulse);
  cover property ($fell(monitor_serial_pin_oe));
endmodule : monitor_entry_security_props

bind monitor_entry_security monitor_entry_security_props #(
  .BIT_CYCLES(BIT_CYCLES), .HOLD_CYCLES(HOLD_CYCLES)) i_props (.*);

// File: bench/monitor_entry_security_tb.sv
// bench: locked and unlocked monitor sessions, flash gating, stack commands
`timescale 1ns/1ps
module monitor_entry_security_tb;
  import monitor_entry_security_pkg::*;
  localparam int BC = 8;
  logic ref_clk, arst_n, sel, host_line, s_out, s_oe, rsp_valid, rpulse, frd_valid, ill, unl;
  logic echo_valid, mon;
  logic [7:0] fdat, frd, echo_byte, d;
  logic [7:0] key [8];
  logic [7:0] fr [7];
  logic [15:0] stack_in, rsp_data, resume_stack;
  logic [15:0] exp_q [$];
  logic [31:0] seed = 32'h00018372;
  cpu_regs_s regs, rregs;
  mon_cmd_s cmd;
  sec_write_s sec_wr;
  flash_req_s freq;
  int failures = 0;
  int cmp_count = 0;
  int ill_n = 0;
  int rp_n = 0;
  int n;

  monitor_entry_security #(.BIT_CYCLES(BC)) i_dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .mode_entry_select_pin(sel),
    .monitor_serial_pin_in(s_oe ? s_out : host_line), .monitor_serial_pin_out(s_out),
    .monitor_serial_pin_oe(s_oe), .cpu_regs_in(regs), .stack_pointer_in(stack_in), .cmd(cmd),
    .rsp_data(rsp_data), .rsp_valid(rsp_valid), .resume_regs(rregs),
    .resume_stack_pointer(resume_stack), .resume_pulse(rpulse), .sec_wr(sec_wr), .flash_req(freq),
    .flash_array_data(fdat), .flash_rd_data(frd), .flash_rd_valid(frd_valid),
    .illegal_addr_reset(ill), .monitor_active(mon), .security_unlocked(unl));

  host_serial_model #(.BIT_CYCLES(BC)) i_host (.ref_clk(ref_clk), .dev_out(s_out),
    .dev_oe(s_oe), .host_line(host_line), .echo_byte(echo_byte), .echo_valid(echo_valid));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd

  task automatic tick(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic take(input logic [15:0] g, input string nm);
    chk(nm, (exp_q.size() != 0) ? exp_q.pop_front() : 16'hxxxx, g);
  endtask : take

  // select stays low through reset and the whole hold window
  task automatic entry();
    arst_n = 1'b0;
    tick(6);
    arst_n = 1'b1;
    tick(ENTRY_HOLD_CYCLES + 4);
  endtask : entry

  task automatic session(input logic bad);
    logic [7:0] b;
    for (int k = 0; k < 8; k++) begin
      b = (bad && k == 7) ? ~key[k] : key[k];
      exp_q.push_back({8'h00, b});
      i_host.send(b);
    end
    tick(4);
  endtask : session

  task automatic issue(input mon_cmd_e op, input logic [2:0] ofs, input logic [7:0] v);
    cmd = '{1'b1, op, ofs, v};
    tick(1);
    cmd.valid = 1'b0;
    tick(1);
  endtask : issue

  task automatic access(input logic f, input logic [15:0] a);
    freq = '{1'b1, f, a};
    tick(1);
    freq.valid = 1'b0;
    tick(2);
  endtask : access

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  always @(posedge ref_clk) begin
    if (ill) ill_n <= ill_n + 1;
    if (rpulse) rp_n <= rp_n + 1;
    if (echo_valid) take({8'h00, echo_byte}, "echo");
    if (rsp_valid) take(rsp_data, "response");
    if (frd_valid) take({8'h00, frd}, "flash read");
  end

  initial begin
    tick(40000);
    failures++;
    conclude();
  end

  initial begin
    arst_n = 1'b0;
    sel = 1'b0;
    cmd = '0;
    sec_wr = '0;
    freq = '0;
    fdat = 8'h00;
    stack_in = {8'h01, rnd()};
    regs = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
    fr = '{8'h00, regs.index_high, regs.ccr, regs.acc, regs.index_low, regs.pc[15:8], regs.pc[7:0]};
    entry();
    for (int k = 0; k < 8; k++) begin
      key[k] = rnd();
      sec_wr = '{1'b1, k[2:0], key[k]};
      tick(1);
    end
    sec_wr.en = 1'b0;
    // last byte wrong: whole compare must fail
    session(1'b1);
    chk("unlocked", 16'h0000, {15'h0000, unl});
    chk("monitor", 16'h0001, {15'h0000, mon});
    fdat = rnd();
    exp_q.push_back({8'h00, UNDEF_BYTE});
    access(1'b0, SEC_BASE_ADDR);
    n = ill_n;
    access(1'b1, FLASH_LO_ADDR);
    chk("illegal reset", 16'h0001, 16'(ill_n - n));
    entry();
    chk("relocked", 16'h0000, {15'h0000, unl});
    foreach (key[k]) key[k] = ERASED_BYTE;
    session(1'b0);
    chk("unlocked", 16'h0001, {15'h0000, unl});
    fdat = rnd();
    exp_q.push_back({8'h00, fdat});
    access(1'b0, 16'hf000);
    n = ill_n;
    access(1'b1, FLASH_LO_ADDR);
    chk("unlocked fetch", 16'h0000, 16'(ill_n - n));
    exp_q.push_back(stack_in - 16'h0005);
    issue(read_stack_pointer_command, 3'h0, 8'h00);
    for (int k = 0; k < 7; k++) begin
      exp_q.push_back({8'h00, fr[k]});
      issue(cmd_read_stack, k[2:0], 8'h00);
    end
    d = rnd();
    issue(cmd_write_stack, 3'h6, d);
    n = rp_n;
    issue(cmd_resume, 3'h0, 8'h00);
    tick(2);
    chk("resume pulse", 16'h0001, 16'(rp_n - n));
    chk("resume pc", {regs.pc[15:8], d}, rregs.pc);
    chk("resume index", {regs.index_high, regs.index_low}, {rregs.index_high, rregs.index_low});
    chk("resume acc ccr", {regs.acc, regs.ccr}, {rregs.acc, rregs.ccr});
    chk("resume stack", stack_in, resume_stack);
    entry();
    chk("relocked", 16'h0000, {15'h0000, unl});
    // select high in the hold window: user mode, no gating and no trap
    arst_n = 1'b0;
    tick(6);
    arst_n = 1'b1;
    sel = 1'b1;
    tick(2);
    sel = 1'b0;
    tick(ENTRY_HOLD_CYCLES + 4);
    chk("user mode", 16'h0000, {15'h0000, mon});
    fdat = rnd();
    exp_q.push_back({8'h00, fdat});
    access(1'b0, SEC_BASE_ADDR);
    n = ill_n;
    access(1'b1, FLASH_LO_ADDR);
    chk("user fetch", 16'h0000, 16'(ill_n - n));
    chk("pending notes", 16'h0000, 16'(exp_q.size()));
    conclude();
  end
endmodule : monitor_entry_security_tb

// File: logic/monitor_entry_security.sv
// monitor-mode entry, security byte check, stacked frame and flash gating
`timescale 1ns/1ps
module monitor_entry_security import monitor_entry_security_pkg::*; #(
  parameter int BIT_CYCLES = 1024,
  parameter int HOLD_CYCLES = ENTRY_HOLD_CYCLES
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic mode_entry_select_pin,
  input wire logic monitor_serial_pin_in,
  output logic monitor_serial_pin_out,
  output logic monitor_serial_pin_oe,
  input wire cpu_regs_s cpu_regs_in,
  input wire logic [15:0] stack_pointer_in,
  input wire mon_cmd_s cmd,
  output logic [15:0] rsp_data,
  output logic rsp_valid,
  output cpu_regs_s resume_regs,
  output logic [15:0] resume_stack_pointer,
  output logic resume_pulse,
  input wire sec_write_s sec_wr,
  input wire flash_req_s flash_req,
  input wire logic [7:0] flash_array_data,
  output logic [7:0] flash_rd_data,
  output logic flash_rd_valid,
  output logic illegal_addr_reset,
  output logic monitor_active,
  output logic security_unlocked
);

  typedef enum logic [2:0] {
    st_entry,
    st_rx_idle,
    st_rx_bits,
    st_tx,
    st_monitor,
    st_user
  } mon_state_e;

  localparam int TMR_W = $clog2(BIT_CYCLES + 1);
  localparam logic [TMR_W-1:0] TMR_FULL = TMR_W'(BIT_CYCLES - 1);
  localparam logic [TMR_W-1:0] TMR_HALF = TMR_W'(BIT_CYCLES / 2);
  localparam logic [4:0] HOLD_LAST = 5'(HOLD_CYCLES - 1);

  mon_state_e state, next_state;
  logic [4:0] hold_cnt, next_hold_cnt;
  logic [TMR_W-1:0] tmr, next_tmr;
  logic [3:0] bit_idx, next_bit_idx;
  logic [SEC_IDX_W-1:0] byte_cnt, next_byte_cnt;
  logic [7:0] shreg, next_shreg;
  logic mismatch, next_mismatch;
  logic unlocked, next_unlocked;
  logic tx_out, next_tx_out;
  logic tx_oe, next_tx_oe;
  logic [7:0] frame [1:6];
  logic [7:0] next_frame [1:6];
  logic [15:0] stack_ptr, next_stack_ptr;
  logic [15:0] next_rsp_data;
  logic next_rsp_valid;
  cpu_regs_s next_resume_regs;
  logic [15:0] next_resume_stack_ptr;
  logic next_resume_pulse;
  logic [7:0] next_flash_rd_data;
  logic next_flash_rd_valid;
  logic next_illegal;
  logic [7:0] sec_rd_data;
  logic in_monitor;

  security_byte_store #(
    .DEPTH(SEC_BYTES)
  ) u_store (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .wr(sec_wr),
    .rd_idx(byte_cnt),
    .rd_data(sec_rd_data)
  );

  assign in_monitor = (state != st_entry) && (state != st_user);

  // entry, serial receive, echo and compare
  always_comb begin
    next_state = state;
    next_hold_cnt = hold_cnt;
    next_tmr = tmr;
    next_bit_idx = bit_idx;
    next_byte_cnt = byte_cnt;
    next_shreg = shreg;
    next_mismatch = mismatch;
    next_unlocked = unlocked;
    next_tx_out = tx_out;
    next_tx_oe = tx_oe;
    case (state)
      st_entry: begin
        // a high select pin at any cycle of the hold window means user mode
        if (mode_entry_select_pin) begin
          next_state = st_user;
        end else if (hold_cnt == HOLD_LAST) begin
          next_state = st_rx_idle;
        end else begin
          next_hold_cnt = hold_cnt + 5'h01;
        end
      end
      st_rx_idle: begin
        if (!monitor_serial_pin_in) begin
          next_state = st_rx_bits;
          next_tmr = TMR_HALF;
          next_bit_idx = BIT_START;
        end
      end
      st_rx_bits: begin
        if (tmr != '0) begin
          next_tmr = tmr - 1'b1;
        end else if (bit_idx == BIT_START && monitor_serial_pin_in) begin
          next_state = st_rx_idle; // false start, glitch rejected
        end else if (bit_idx == BIT_STOP) begin
          // one differing byte spoils the whole sequence
          next_mismatch = mismatch | (shreg != sec_rd_data);
          next_state = st_tx;
          next_tmr = TMR_FULL;
          next_bit_idx = BIT_START;
          next_tx_out = 1'b0;
          next_tx_oe = 1'b1;
        end else begin
          if (bit_idx != BIT_START) begin
            next_shreg = {monitor_serial_pin_in, shreg[7:1]};
          end
          next_bit_idx = bit_idx + 4'h1;
          next_tmr = TMR_FULL;
        end
      end
      st_tx: begin
        if (tmr != '0) begin
          next_tmr = tmr - 1'b1;
        end else if (bit_idx == BIT_STOP) begin
          next_tx_oe = 1'b0;
          next_tx_out = 1'b1;
          if (byte_cnt == SEC_IDX_W'(SEC_BYTES - 1)) begin
            next_state = st_monitor;
            next_unlocked = !mismatch;
          end else begin
            next_state = st_rx_idle;
            next_byte_cnt = byte_cnt + 1'b1;
          end
        end else begin
          next_bit_idx = bit_idx + 4'h1;
          next_tmr = TMR_FULL;
          // data lsb first, then the stop level
          next_tx_out = (bit_idx == 4'h8) ? 1'b1 : shreg[bit_idx[2:0]];
        end
      end
      st_monitor: begin
        next_state = st_monitor;
      end
      st_user: begin
        next_state = st_user;
      end
      default: begin
        next_state = st_entry;
      end
    endcase
  end

  // unlock is only ever cleared by reset, so any reset relocks
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= st_entry;
      hold_cnt <= 5'h00;
      tmr <= '0;
      bit_idx <= 4'h0;
      byte_cnt <= '0;
      shreg <= 8'h00;
      mismatch <= 1'b0;
      unlocked <= 1'b0;
      tx_out <= 1'b1;
      tx_oe <= 1'b0;
    end else begin
      state <= next_state;
      hold_cnt <= next_hold_cnt;
      tmr <= next_tmr;
      bit_idx <= next_bit_idx;
      byte_cnt <= next_byte_cnt;
      shreg <= next_shreg;
      mismatch <= next_mismatch;
      unlocked <= next_unlocked;
      tx_out <= next_tx_out;
      tx_oe <= next_tx_oe;
    end
  end

  // stacked frame and monitor commands
  always_comb begin
    for (int i = 1; i <= 6; i++) begin
      next_frame[i] = frame[i];
    end
    next_stack_ptr = stack_ptr;
    next_rsp_data = rsp_data;
    next_rsp_valid = 1'b0;
    next_resume_regs = resume_regs;
    next_resume_stack_ptr = resume_stack_pointer;
    next_resume_pulse = 1'b0;
    if (state == st_entry && next_state == st_rx_idle) begin
      // software interrupt stacks five bytes, then index high is pushed
      next_frame[OFS_INDEX_HIGH] = cpu_regs_in.index_high;
      next_frame[OFS_CCR] = cpu_regs_in.ccr;
      next_frame[OFS_ACC] = cpu_regs_in.acc;
      next_frame[OFS_INDEX_LOW] = cpu_regs_in.index_low;
      next_frame[OFS_PC_HIGH] = cpu_regs_in.pc[15:8];
      next_frame[OFS_PC_LOW] = cpu_regs_in.pc[7:0];
      next_stack_ptr = stack_pointer_in - ENTRY_PUSH_BYTES;
    end else if (state == st_monitor && cmd.valid) begin
      case (cmd.op)
        cmd_write_stack: begin
          if (cmd.offset >= OFS_INDEX_HIGH && cmd.offset <= OFS_PC_LOW) begin
            next_frame[cmd.offset] = cmd.data;
          end
        end
        cmd_read_stack: begin
          next_rsp_valid = 1'b1;
          if (cmd.offset >= OFS_INDEX_HIGH && cmd.offset <= OFS_PC_LOW) begin
            next_rsp_data = {8'h00, frame[cmd.offset]};
          end else begin
            next_rsp_data = 16'h0000;
          end
        end
        read_stack_pointer_command: begin
          next_rsp_valid = 1'b1;
          next_rsp_data = stack_ptr + STACK_READ_BIAS;
        end
        cmd_resume: begin
          // pull index high first, then the interrupt return frame
          next_resume_regs.index_high = frame[OFS_INDEX_HIGH];
          next_resume_regs.ccr = frame[OFS_CCR];
          next_resume_regs.acc = frame[OFS_ACC];
          next_resume_regs.index_low = frame[OFS_INDEX_LOW];
          next_resume_regs.pc = {frame[OFS_PC_HIGH], frame[OFS_PC_LOW]};
          next_resume_stack_ptr = stack_ptr + ENTRY_PUSH_BYTES;
          next_resume_pulse = 1'b1;
        end
        default: begin
          next_rsp_valid = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 1; i <= 6; i++) begin
        frame[i] <= 8'h00;
      end
      stack_ptr <= 16'h0000;
      rsp_data <= 16'h0000;
      rsp_valid <= 1'b0;
      resume_regs <= '0;
      resume_stack_pointer <= 16'h0000;
      resume_pulse <= 1'b0;
    end else begin
      frame <= next_frame;
      stack_ptr <= next_stack_ptr;
      rsp_data <= next_rsp_data;
      rsp_valid <= next_rsp_valid;
      resume_regs <= next_resume_regs;
      resume_stack_pointer <= next_resume_stack_ptr;
      resume_pulse <= next_resume_pulse;
    end
  end

  // flash gating; locked means in monitor without a good match
  always_comb begin
    next_flash_rd_valid = flash_req.valid && !flash_req.fetch;
    next_flash_rd_data = flash_rd_data;
    next_illegal = 1'b0;
    if (flash_req.valid && flash_req.addr >= FLASH_LO_ADDR) begin
      if (in_monitor && !unlocked) begin
        // fixed filler so nothing of the stored image leaks
        next_flash_rd_data = UNDEF_BYTE;
        next_illegal = flash_req.fetch;
      end else begin
        next_flash_rd_data = flash_array_data;
      end
    end else if (flash_req.valid) begin
      next_flash_rd_data = flash_array_data;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      flash_rd_data <= 8'h00;
      flash_rd_valid <= 1'b0;
      illegal_addr_reset <= 1'b0;
    end else begin
      flash_rd_data <= next_flash_rd_data;
      flash_rd_valid <= next_flash_rd_valid;
      illegal_addr_reset <= next_illegal;
    end
  end

  assign monitor_serial_pin_out = tx_out;
  assign monitor_serial_pin_oe = tx_oe;
  assign monitor_active = in_monitor;
  assign security_unlocked = unlocked;

endmodule : monitor_entry_security

// File: logic/monitor_entry_security_pkg.sv
// shared constants and carriers for monitor entry and security check
package monitor_entry_security_pkg;

  localparam int ENTRY_HOLD_CYCLES = 24;
  localparam int SEC_BYTES = 8;
  localparam int SEC_IDX_W = 3;
  localparam logic [15:0] SEC_BASE_ADDR = 16'hfff6;
  localparam logic [15:0] SEC_LAST_ADDR = 16'hfffd;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] UNDEF_BYTE = 8'h00;
  localparam logic [15:0] FLASH_LO_ADDR = 16'he000;

  localparam int FRAME_BITS = 10;
  localparam logic [3:0] BIT_START = 4'h0;
  localparam logic [3:0] BIT_STOP = 4'h9;

  localparam logic [2:0] OFS_INDEX_HIGH = 3'h1;
  localparam logic [2:0] OFS_CCR = 3'h2;
  localparam logic [2:0] OFS_ACC = 3'h3;
  localparam logic [2:0] OFS_INDEX_LOW = 3'h4;
  localparam logic [2:0] OFS_PC_HIGH = 3'h5;
  localparam logic [2:0] OFS_PC_LOW = 3'h6;
  localparam logic [15:0] ENTRY_PUSH_BYTES = 16'h0006;
  localparam logic [15:0] STACK_READ_BIAS = 16'h0001;

  typedef enum logic [1:0] {
    cmd_write_stack,
    cmd_read_stack,
    read_stack_pointer_command,
    cmd_resume
  } mon_cmd_e;

  typedef struct packed {
    logic [7:0] index_high;
    logic [7:0] index_low;
    logic [7:0] acc;
    logic [7:0] ccr;
    logic [15:0] pc;
  } cpu_regs_s;

  typedef struct packed {
    logic valid;
    mon_cmd_e op;
    logic [2:0] offset;
    logic [7:0] data;
  } mon_cmd_s;

  typedef struct packed {
    logic valid;
    logic fetch;
    logic [15:0] addr;
  } flash_req_s;

  typedef struct packed {
    logic en;
    logic [SEC_IDX_W-1:0] idx;
    logic [7:0] data;
  } sec_write_s;

endpackage : monitor_entry_security_pkg

// File: logic/security_byte_store.sv
// eight-byte store of the reserved security bytes, registered read
`timescale 1ns/1ps
module security_byte_store import monitor_entry_security_pkg::*; #(
  parameter int DEPTH = SEC_BYTES
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire sec_write_s wr,
  input wire logic [SEC_IDX_W-1:0] rd_idx,
  output logic [7:0] rd_data
);

  logic [7:0] mem [DEPTH];
  logic [7:0] next_mem [DEPTH];
  logic [7:0] next_rd_data;

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      next_mem[i] = mem[i];
    end
    if (wr.en) begin
      next_mem[wr.idx] = wr.data;
    end
    next_rd_data = mem[rd_idx];
  end

  // erased flash reads as all ones until programmed
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= ERASED_BYTE;
      end
      rd_data <= ERASED_BYTE;
    end else begin
      mem <= next_mem;
      rd_data <= next_rd_data;
    end
  end

endmodule : security_byte_store
